// >>> core/fsp_ctrl.sv
// Flash self-programming controller: control register, pointer, page buffer
// Assumes a core that strobes store/load program instructions and a flash array
// that acknowledges each started operation with a done pulse.
// Pages below RWW_PAGES form the read-while-write section.
//
// What this block does
// R1: Control bit 5 is reserved and always reads zero.
// R2: Erase or write to read-while-write section sets busy flag and blocks reads.
// R3: Re-enable code plus store instruction within four cycles re-enables that section.
// R4: Re-enable is refused while an erase or write is in progress.
// R5: Writing the re-enable bit during buffer loading discards buffered data.
// R6: Lock code plus store within four cycles programs lock bits from low operand.
// R7: Load within three cycles of lock arming returns lock or fuse bits.
// R8: Write code plus store within four cycles programs buffer into pointer page.
// R9: Erase code plus store within four cycles erases pointer page.
// R10: Erase and write bits self-clear on completion or arming timeout.
// R11: Stall core for other-section operations; read-while-write ops keep other readable.
// R12: Enable alone makes store load operand word into buffer at pointer word.
// R13: Enable waits four cycles for a store; stays set during erase or write.
// R14: Writes with any other low five bit code arm nothing; with bit 4 set they still discard the buffer.
// R15: Pointer is low byte, high byte and extension bit at position 16.
// R16: Page address is latched at operation start.
// R17: Load reads flash bytewise, pointer bit 0 picks the byte.
// R18: Buffer erased after page write, on re-enable write and on reset.
// R19: Software loads each buffer word at most once between erasures.
// R20: An EEPROM write during partial buffer load discards buffered data.
// R21: Ready interrupt asserted while enabled and the enable bit is clear.
// R22: Software erases a page before writing it, with the same address.
// R23: Busy flag clears when a buffer load starts.
// R24: Ready interrupt needs both its enable bit and the global interrupt bit.
// R25: Arming window is a cycle counter started by a control write.
`timescale 1ns/1ps
`include "fsp_consts.svh"

module fsp_ctrl #(
  parameter int WORD_IDX_W = 7,
  parameter int RWW_PAGES = 448,
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Core side
  input wire logic spm_i,
  input wire logic lpm_i,
  input wire logic [7:0] low_operand_i,
  input wire logic [7:0] high_operand_i,
  input wire logic global_irq_i,
  input wire logic eeprom_write_i,
  output logic [7:0] lpm_data_o,
  output logic lpm_valid_o,
  output logic cpu_stall_o,
  output logic rww_read_block_o,
  output logic ready_irq_o,
  // Fuse and lock inputs
  input wire logic [7:0] lock_bits_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] fuse_high_i,
  input wire logic [7:0] fuse_ext_i,
  // Flash array side
  input wire logic [15:0] flash_word_i,
  output logic [15:0] flash_word_addr_o,
  output fsp_pkg::fsp_cmd_s flash_cmd_o,
  output logic flash_start_o,
  input wire logic flash_done_i,
  input wire logic [WORD_IDX_W-1:0] buf_raddr_i,
  output logic [15:0] buf_rdata_o
);

  // Page buffer geometry follows the word index width
  localparam int PAGE_WORDS = 1 << WORD_IDX_W;
  localparam int PAGE_W = 16 - WORD_IDX_W;

  fsp_pkg::fsp_state_e state_reg;
  fsp_pkg::fsp_op_e op_reg;
  logic [4:0] cmd_reg;
  logic irq_en_reg;
  logic busy_flag_reg;
  logic no_read_while_write_section_op_reg;
  logic [2:0] win_reg;
  logic ext_reg;
  logic [7:0] phi_reg;
  logic [7:0] plo_reg;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [PAGE_WORDS-1:0] buf_valid_reg;
  logic [PAGE_WORDS-1:0] buf_valid_next;
  logic [16:0] ptr;
  // Pointer split into page and word fields
  logic [PAGE_W-1:0] page_idx;
  logic [WORD_IDX_W-1:0] word_idx;
  logic ctrl_wr;
  logic cmd_valid;
  logic spm_take;
  logic lpm_lock_take;
  logic buf_clear;
  logic load_take;
  logic [7:0] ctrl_rd;
  logic [7:0] fuse_sel;

  assign ptr = {ext_reg, phi_reg, plo_reg}; // R15
  assign page_idx = ptr[16:WORD_IDX_W+1];
  assign word_idx = ptr[WORD_IDX_W:1]; // R12

  // Control register write and command decode
  assign ctrl_wr = reg_wr_i && (reg_addr_i == `FSP_OFS_CTRL);
  always_comb begin
    case (reg_wdata_i[4:0])
      `FSP_CMD_REEN,
      `FSP_CMD_LOCK,
      `FSP_CMD_WRITE,
      `FSP_CMD_ERASE,
      `FSP_CMD_LOAD: cmd_valid = 1'b1;
      default: cmd_valid = 1'b0; // R14
    endcase
  end

  // Store accepted inside the arming window
  assign spm_take = spm_i && (state_reg == fsp_pkg::FSP_ST_ARMED) && (win_reg != 3'h0); // R25
  // Load of lock or fuse bits inside the shorter window
  assign lpm_lock_take = lpm_i && (state_reg == fsp_pkg::FSP_ST_ARMED)
    && (cmd_reg == `FSP_CMD_LOCK) && (win_reg > (`FSP_SPM_WINDOW - `FSP_LPM_WINDOW)); // R7
  assign load_take = spm_take && (cmd_reg == `FSP_CMD_LOAD);

  // Buffer discard: re-enable write, EEPROM write, after page write
  assign buf_clear = (ctrl_wr && reg_wdata_i[`FSP_BIT_REEN]) // R5 R18
    || eeprom_write_i // R20
    || (flash_done_i && state_reg == fsp_pkg::FSP_ST_BUSY && op_reg == fsp_pkg::FSP_OP_WRITE); // R18

  // Control state machine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= fsp_pkg::FSP_ST_IDLE;
      cmd_reg <= 5'h00;
      win_reg <= 3'h0;
      op_reg <= fsp_pkg::FSP_OP_NONE;
    end else begin
      case (state_reg)
        fsp_pkg::FSP_ST_IDLE: begin
          if (ctrl_wr && cmd_valid) begin
            cmd_reg <= reg_wdata_i[4:0];
            win_reg <= `FSP_SPM_WINDOW; // R25
            state_reg <= fsp_pkg::FSP_ST_ARMED;
          end
        end
        fsp_pkg::FSP_ST_ARMED: begin
          if (spm_take) begin
            case (cmd_reg)
              `FSP_CMD_ERASE: begin
                op_reg <= fsp_pkg::FSP_OP_ERASE; // R9
                state_reg <= fsp_pkg::FSP_ST_BUSY; // R13
              end
              `FSP_CMD_WRITE: begin
                op_reg <= fsp_pkg::FSP_OP_WRITE; // R8
                state_reg <= fsp_pkg::FSP_ST_BUSY; // R13
              end
              `FSP_CMD_LOCK: begin
                op_reg <= fsp_pkg::FSP_OP_LOCK; // R6
                state_reg <= fsp_pkg::FSP_ST_BUSY;
              end
              default: begin
                cmd_reg <= 5'h00; // R12 R3
                state_reg <= fsp_pkg::FSP_ST_IDLE;
              end
            endcase
            win_reg <= 3'h0;
          end else if (lpm_lock_take || win_reg <= 3'h1) begin
            cmd_reg <= 5'h00; // R10 R13 R6
            win_reg <= 3'h0;
            state_reg <= fsp_pkg::FSP_ST_IDLE;
          end else begin
            win_reg <= win_reg - 3'h1;
          end
        end
        fsp_pkg::FSP_ST_BUSY: begin
          // Control writes leave the state machine alone until the operation ends
          if (flash_done_i) begin
            cmd_reg <= 5'h00; // R10 R13 R4
            op_reg <= fsp_pkg::FSP_OP_NONE;
            state_reg <= fsp_pkg::FSP_ST_IDLE;
          end
        end
        default: begin
          state_reg <= fsp_pkg::FSP_ST_IDLE;
          cmd_reg <= 5'h00;
        end
      endcase
    end
  end

  // Interrupt enable bit is written on any control write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_reg <= reg_wdata_i[`FSP_BIT_IRQEN];
    end
  end

  // Section busy flag and core stall
  // Lock operations neither stall nor set busy
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_flag_reg <= 1'b0;
      no_read_while_write_section_op_reg <= 1'b0;
    end else if (spm_take && (cmd_reg == `FSP_CMD_ERASE || cmd_reg == `FSP_CMD_WRITE)) begin
      if (32'(page_idx) < RWW_PAGES) begin
        busy_flag_reg <= 1'b1; // R2
      end else begin
        no_read_while_write_section_op_reg <= 1'b1; // R11
      end
    end else if (spm_take && (cmd_reg == `FSP_CMD_REEN || cmd_reg == `FSP_CMD_LOAD)) begin
      busy_flag_reg <= 1'b0; // R3 R23
    end else if (flash_done_i && state_reg == fsp_pkg::FSP_ST_BUSY) begin
      no_read_while_write_section_op_reg <= 1'b0;
    end
  end

  // Registered stall and read block outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cpu_stall_o <= 1'b0;
      rww_read_block_o <= 1'b0;
    end else begin
      cpu_stall_o <= no_read_while_write_section_op_reg && !(flash_done_i && state_reg == fsp_pkg::FSP_ST_BUSY); // R11
      rww_read_block_o <= busy_flag_reg; // R2
    end
  end

  // Flash command with latched page address
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flash_cmd_o <= '0;
      flash_start_o <= 1'b0;
    end else begin
      flash_start_o <= 1'b0;
      if (spm_take && (cmd_reg == `FSP_CMD_ERASE || cmd_reg == `FSP_CMD_WRITE
          || cmd_reg == `FSP_CMD_LOCK)) begin
        flash_start_o <= 1'b1;
        flash_cmd_o.page <= 16'(page_idx); // R16
        // Operand registers only matter for the lock update
        flash_cmd_o.lock_data <= (cmd_reg == `FSP_CMD_LOCK) ? low_operand_i : 8'h00; // R6
        case (cmd_reg)
          `FSP_CMD_ERASE: flash_cmd_o.op <= fsp_pkg::FSP_OP_ERASE;
          `FSP_CMD_WRITE: flash_cmd_o.op <= fsp_pkg::FSP_OP_WRITE;
          default: flash_cmd_o.op <= fsp_pkg::FSP_OP_LOCK;
        endcase
      end else if (flash_done_i && state_reg == fsp_pkg::FSP_ST_BUSY) begin
        flash_cmd_o.op <= fsp_pkg::FSP_OP_NONE;
      end
    end
  end

  // Pointer registers
  // Extension bit kept only when program space needs it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_reg <= 1'b0;
      phi_reg <= `FSP_RST_BYTE;
      plo_reg <= `FSP_RST_BYTE;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `FSP_OFS_EXT && HAS_EXT) begin
        ext_reg <= reg_wdata_i[0]; // R15
      end
      if (reg_addr_i == `FSP_OFS_PHI) begin
        phi_reg <= reg_wdata_i;
      end
      if (reg_addr_i == `FSP_OFS_PLO) begin
        plo_reg <= reg_wdata_i;
      end
    end
  end

  // Temporary page buffer valid bits
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_valid
      always_comb begin
        if (buf_clear) begin
          buf_valid_next[gi] = 1'b0; // R18
        end else if (load_take && word_idx == WORD_IDX_W'(gi)) begin
          buf_valid_next[gi] = 1'b1;
        end else begin
          buf_valid_next[gi] = buf_valid_reg[gi];
        end
      end
    end
  endgenerate

  // Loaded-word map, cleared with the buffer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_valid_reg <= '0; // R18
    end else begin
      buf_valid_reg <= buf_valid_next;
    end
  end

  // Word storage needs no reset behind the valid map
  always_ff @(posedge clk_i) begin
    if (load_take && !buf_clear) begin
      buf_mem[word_idx] <= {high_operand_i, low_operand_i}; // R12
    end
  end

  // Unloaded words read as erased flash
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_rdata_o <= `FSP_ERASED_WORD;
    end else begin
      buf_rdata_o <= buf_valid_reg[buf_raddr_i] ? buf_mem[buf_raddr_i] : `FSP_ERASED_WORD;
    end
  end

  // Load program instruction results
  always_comb begin
    case (ptr[1:0])
      `FSP_SEL_FUSE_LO: fuse_sel = fuse_low_i;
      `FSP_SEL_LOCK: fuse_sel = lock_bits_i;
      `FSP_SEL_FUSE_EXT: fuse_sel = fuse_ext_i;
      default: fuse_sel = fuse_high_i;
    endcase
  end

  // Flash word address lags the pointer by one cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lpm_data_o <= 8'h00;
      lpm_valid_o <= 1'b0;
      flash_word_addr_o <= 16'h0000;
    end else begin
      lpm_valid_o <= lpm_i;
      flash_word_addr_o <= ptr[16:1];
      if (lpm_lock_take) begin
        lpm_data_o <= fuse_sel; // R7
      end else if (lpm_i) begin
        lpm_data_o <= ptr[0] ? flash_word_i[15:8] : flash_word_i[7:0]; // R17
      end
    end
  end

  // Ready interrupt
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready_irq_o <= 1'b0;
    end else begin
      ready_irq_o <= irq_en_reg && global_irq_i && !cmd_reg[`FSP_BIT_ENABLE]; // R21 R24
    end
  end

  // Register read, data one cycle after the strobe
  // Reserved control bit tied low
  assign ctrl_rd = {irq_en_reg, busy_flag_reg, 1'b0, cmd_reg}; // R1
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `FSP_OFS_CTRL: reg_rdata_o <= ctrl_rd;
        `FSP_OFS_EXT: reg_rdata_o <= {7'h00, ext_reg};
        `FSP_OFS_PHI: reg_rdata_o <= phi_reg;
        default: reg_rdata_o <= plo_reg;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

// >>> core/fsp_consts.svh
// Constants of the flash self-programming controller
// Assumes inclusion by bare name from core/
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Register indices on the plain register port
`define FSP_OFS_CTRL 2'h0
`define FSP_OFS_EXT 2'h1
`define FSP_OFS_PHI 2'h2
`define FSP_OFS_PLO 2'h3

// Control register bit positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REEN 4
`define FSP_BIT_RSVD 5
`define FSP_BIT_BUSY 6
`define FSP_BIT_IRQEN 7

// Valid command codes in the low five bits
`define FSP_CMD_REEN 5'h11
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_LOAD 5'h01

// Reset values
`define FSP_RST_CTRL 8'h00
`define FSP_RST_BYTE 8'h00
`define FSP_ERASED_WORD 16'hFFFF

// Arming windows in clock cycles
`define FSP_SPM_WINDOW 3'h4
`define FSP_LPM_WINDOW 3'h3

// Pointer select codes for fuse and lock reads
`define FSP_SEL_FUSE_LO 2'h0
`define FSP_SEL_LOCK 2'h1
`define FSP_SEL_FUSE_EXT 2'h2
`define FSP_SEL_FUSE_HI 2'h3

`endif

// >>> core/fsp_pkg.sv
// Types of the flash self-programming controller
// Assumes the constants header beside it
package fsp_pkg;

  typedef enum logic [1:0] {
    FSP_OP_NONE,
    FSP_OP_ERASE,
    FSP_OP_WRITE,
    FSP_OP_LOCK
  } fsp_op_e;

  typedef enum logic [1:0] {
    FSP_ST_IDLE,
    FSP_ST_ARMED,
    FSP_ST_BUSY
  } fsp_state_e;

  // Command handed to the flash array
  typedef struct packed {
    fsp_op_e op;
    logic [15:0] page;
    logic [7:0] lock_data;
  } fsp_cmd_s;

endpackage

// >>> dv/fsp_ctrl_checker.sv
// Port checker for the flash self-programming controller
// Assumes binding to fsp_ctrl; one clock, synchronous reset
`timescale 1ns/1ps
module fsp_ctrl_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic spm_i,
  input wire logic lpm_i,
  input wire logic global_irq_i,
  input wire logic lpm_valid_o,
  input wire logic cpu_stall_o,
  input wire logic rww_read_block_o,
  input wire logic ready_irq_o,
  input wire fsp_pkg::fsp_cmd_s flash_cmd_o,
  input wire logic flash_start_o,
  input wire logic flash_done_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_rsvd_reads_zero: assert property ($past(reg_rd_i) |-> !reg_rdata_o[5])
    else $error("reserved control bit read as one");
  a_irq_needs_global: assert property (ready_irq_o |-> $past(global_irq_i))
    else $error("ready interrupt without global enable");
  a_irq_off_busy: assert property (cpu_stall_o |-> !ready_irq_o)
    else $error("ready interrupt during operation");
  a_start_after_store: assert property (flash_start_o |-> $past(spm_i))
    else $error("flash start without store");
  a_stall_on_start: assert property ($rose(cpu_stall_o) |-> $past(flash_start_o))
    else $error("stall without operation start");
  a_stall_holds: assert property (cpu_stall_o && !flash_done_i |=> cpu_stall_o)
    else $error("stall dropped before done");
  a_stall_ends_done: assert property ($fell(cpu_stall_o) |-> $past(flash_done_i))
    else $error("stall ended without done");
  a_load_answer: assert property (lpm_valid_o == $past(lpm_i))
    else $error("load answer not one cycle after load");
  a_block_after_start: assert property ($rose(rww_read_block_o) |-> $past(flash_start_o))
    else $error("read block without operation start");
  a_block_no_stall: assert property (!(cpu_stall_o && rww_read_block_o))
    else $error("stall and read block together");
  a_page_latched: assert property (cpu_stall_o && $past(cpu_stall_o) |-> $stable(flash_cmd_o.page))
    else $error("page moved during operation");
  c_stall: cover property ($rose(cpu_stall_o));
  c_block: cover property ($rose(rww_read_block_o));
  c_lock: cover property (flash_start_o && flash_cmd_o.op == fsp_pkg::FSP_OP_LOCK);
  c_load: cover property (lpm_valid_o);
endmodule

// >>> dv/fsp_flash_model.sv
// Flash array model: answers each start with a done pulse
// Assumes one start pulse per operation; word read is combinational
`timescale 1ns/1ps
module fsp_flash_model #(
  parameter int DLY = 12
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] word_o,
  output logic done_o
);
  int cnt;
  assign word_o = addr_i ^ 16'h5A3C;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (srst_i) begin
      cnt <= 0;
    end else if (start_i) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      done_o <= (cnt == 1);
    end
  end
endmodule

// >>> dv/tb.sv
// Testbench of the flash self-programming controller
// Assumes the flash model beside it and the checker bound below
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
  logic clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, spm_i = 0, lpm_i = 0;
  logic global_irq_i = 0, eeprom_write_i = 0, lpm_valid_o, cpu_stall_o, rww_read_block_o;
  logic ready_irq_o, flash_start_o, flash_done_i;
  logic [1:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o, low_operand_i = 0, high_operand_i = 0, lpm_data_o;
  logic [7:0] fz [4] = '{8'h3E, 8'hC1, 8'hF4, 8'h9D};
  logic [7:0] bad [5] = '{8'hFF, 8'h3F, 8'h10, 8'hA2, 8'h8F};
  logic [6:0] buf_raddr_i = 0;
  logic [15:0] flash_word_i, flash_word_addr_o, buf_rdata_o;
  fsp_pkg::fsp_cmd_s flash_cmd_o;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  fsp_ctrl u_dut (.clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .spm_i, .lpm_i, .low_operand_i, .high_operand_i, .global_irq_i, .eeprom_write_i, .lpm_data_o,
    .lpm_valid_o, .cpu_stall_o, .rww_read_block_o, .ready_irq_o, .lock_bits_i(fz[1]),
    .fuse_low_i(fz[0]), .fuse_high_i(fz[3]), .fuse_ext_i(fz[2]), .flash_word_i, .flash_word_addr_o,
    .flash_cmd_o, .flash_start_o, .flash_done_i, .buf_raddr_i, .buf_rdata_o);
  fsp_flash_model u_fl (.clk_i, .srst_i, .start_i(flash_start_o), .addr_i(flash_word_addr_o),
    .word_o(flash_word_i), .done_o(flash_done_i));
  task complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("reg", e, reg_rdata_o)
  endtask
  // 0 store, 1 load, 2 eeprom write
  task pulse(input int k);
    @(posedge clk_i);
    {eeprom_write_i, lpm_i, spm_i} <= 3'b001 << k;
    @(posedge clk_i);
    {eeprom_write_i, lpm_i, spm_i} <= 3'b000;
    #1;
  endtask
  task bufchk(input logic [6:0] w, input logic [15:0] e);
    @(posedge clk_i);
    buf_raddr_i <= w;
    @(posedge clk_i);
    #1;
    `CHK("buf", e, buf_rdata_o)
  endtask
  task load(input logic [7:0] lo, input logic [15:0] d);
    wr(3, lo);
    {high_operand_i, low_operand_i} <= d;
    wr(0, 8'h01);
    pulse(0);
  endtask
  task waitdone;
    for (int i = 0; i < 40 && flash_done_i !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK("done", 1'b1, flash_done_i)
    @(posedge clk_i);
    #1;
  endtask
  task opchk(input fsp_pkg::fsp_op_e op, input logic [15:0] pg);
    `CHK("start", 1'b1, flash_start_o)
    `CHK("op", op, flash_cmd_o.op)
    `CHK("page", pg, flash_cmd_o.page)
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(0, 8'h00);
    rd(1, 8'h00);
    bufchk(0, 16'hFFFF);
    foreach (bad[i]) rd(0, 8'h00);
    foreach (bad[i]) begin
      wr(0, bad[i]);
      rd(0, bad[i] & 8'h80);
    end
    @(posedge clk_i);
    global_irq_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("irq", 1'b1, ready_irq_o)
    wr(0, 8'h81);
    @(posedge clk_i);
    #1;
    `CHK("irq", 1'b0, ready_irq_o)
    repeat (4) @(posedge clk_i);
    rd(0, 8'h80);
    `CHK("irq", 1'b1, ready_irq_o)
    @(posedge clk_i);
    global_irq_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("irq", 1'b0, ready_irq_o)
    wr(0, 8'h00);
    load(8'h05, 16'hA55A);
    bufchk(2, 16'hA55A);
    rd(0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      load(8'h08, 16'h1234);
      if (k == 0) wr(0, 8'h11);
      else pulse(2);
      bufchk(4, 16'hFFFF);
      bufchk(2, 16'hFFFF);
    end
    `CHK("irq", 1'b0, ready_irq_o)
    load(8'h02, 16'hBEEF);
    wr(1, 8'hFF);
    rd(1, 8'h01);
    wr(2, 8'hC0);
    wr(0, 8'h03);
    pulse(0);
    opchk(fsp_pkg::FSP_OP_ERASE, 16'h01C0);
    waitdone;
    wr(0, 8'h05);
    pulse(0);
    opchk(fsp_pkg::FSP_OP_WRITE, 16'h01C0);
    wr(2, 8'h00);
    #1;
    `CHK("stall", 1'b1, cpu_stall_o)
    `CHK("page", 16'h01C0, flash_cmd_o.page)
    rd(0, 8'h05);
    waitdone;
    `CHK("stall", 1'b0, cpu_stall_o)
    rd(0, 8'h00);
    bufchk(1, 16'hFFFF);
    wr(1, 8'h00);
    wr(0, 8'h03);
    repeat (2) @(posedge clk_i);
    pulse(0);
    opchk(fsp_pkg::FSP_OP_ERASE, 16'h0000);
    @(posedge clk_i);
    #1;
    `CHK("block", 1'b1, rww_read_block_o)
    `CHK("stall", 1'b0, cpu_stall_o)
    rd(0, 8'h43);
    wr(0, 8'h11);
    pulse(0);
    `CHK("block", 1'b1, rww_read_block_o)
    waitdone;
    rd(0, 8'h40);
    wr(0, 8'h11);
    pulse(0);
    @(posedge clk_i);
    #1;
    `CHK("block", 1'b0, rww_read_block_o)
    rd(0, 8'h00);
    @(posedge clk_i);
    low_operand_i <= 8'hC3;
    wr(0, 8'h09);
    pulse(0);
    `CHK("op", fsp_pkg::FSP_OP_LOCK, flash_cmd_o.op)
    `CHK("lock", 8'hC3, flash_cmd_o.lock_data)
    waitdone;
    rd(0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(3, 8'(i));
      wr(0, 8'h09);
      pulse(1);
      `CHK("fuse", fz[i], lpm_data_o)
      `CHK("lpmv", 1'b1, lpm_valid_o)
    end
    rd(0, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(3, 8'h06 | 8'(b));
      pulse(1);
      `CHK("lpm", (b == 1) ? 8'h5A : 8'h3F, lpm_data_o)
    end
    complete_run;
  end
endmodule
bind fsp_ctrl fsp_ctrl_checker u_chk (.clk_i, .srst_i, .reg_rd_i, .reg_rdata_o, .spm_i, .lpm_i,
  .global_irq_i, .lpm_valid_o, .cpu_stall_o, .rww_read_block_o, .ready_irq_o, .flash_cmd_o,
  .flash_start_o, .flash_done_i);
